// >>> hdl/pbq_fifo.sv
/*
 flip-flop queue of packet numbers with status, one per queue.
 depth set by pbq_top to cover every packet number; push has no full check, and host enqueue is not limited.
*/
`timescale 1ns/100ps
module pbq_fifo
	import pbq_pkg::*;
#(
	parameter int W     = 21,
	parameter int DEPTH = PBQ_PAGES
)(
	input  wire logic clk,
	input  wire logic rst_b,
	pbq_fifo_if.fifo  q
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0]  mem_reg [DEPTH];
	logic [AW-1:0] rd_reg, rd_next, wr_reg, wr_next;
	logic [AW:0]   cnt_reg, cnt_next;
	logic          do_pop;

	always_comb
	begin
		do_pop  = q.pop && (cnt_reg != '0);
		rd_next = rd_reg;
		wr_next = wr_reg;
		cnt_next = cnt_reg;
		if (q.push)
			wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
		if (do_pop)
			rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
		if (q.push && !do_pop)
			cnt_next = cnt_reg + 1'b1;
		else if (!q.push && do_pop)
			cnt_next = cnt_reg - 1'b1;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rd_reg  <= '0;
			wr_reg  <= '0;
			cnt_reg <= '0;
		end
		else
		begin
			rd_reg  <= rd_next;
			wr_reg  <= wr_next;
			cnt_reg <= cnt_next;
		end
	end

	always_ff @(posedge clk)
	begin
		if (q.push)
			mem_reg[wr_reg] <= q.push_data;
	end

	assign q.head      = (cnt_reg != '0) ? mem_reg[rd_reg] : '0;
	assign q.not_empty = (cnt_reg != '0);
endmodule

// >>> hdl/pbq_fifo_if.sv
/*
 interface carrying one packet number queue's push, pop and status.
 assumes one clock shared by both ends.
*/
`timescale 1ns/100ps
interface pbq_fifo_if #(parameter int W = 21);
	logic         push;
	logic [W-1:0] push_data;
	logic         pop;
	logic [W-1:0] head;
	logic         not_empty;
	modport owner (output push, output push_data, output pop,
		input head, input not_empty);
	modport fifo (input push, input push_data, input pop,
		output head, output not_empty);
endinterface

// >>> hdl/pbq_pkg.sv
/*
 package for the packet buffer queue manager: register offsets,
 field positions, reset values, host command codes.
 assumes nothing beyond a SystemVerilog compiler.
*/
package pbq_pkg;
	localparam int PBQ_PAGES   = 24;
	localparam int PBQ_PNUM_W  = 5;
	localparam int PBQ_STAT_W  = 16;
	localparam int PBQ_ADDR_W  = 4;
	localparam int PBQ_DATA_W  = 16;
	// register offsets
	localparam logic [3:0] PBQ_OFS_CTRL    = 4'h0;
	localparam logic [3:0] PBQ_OFS_RESERVE = 4'h1;
	localparam logic [3:0] PBQ_OFS_FREE    = 4'h2;
	localparam logic [3:0] PBQ_OFS_SIZE    = 4'h3;
	localparam logic [3:0] PBQ_OFS_CMD     = 4'h4;
	localparam logic [3:0] PBQ_OFS_PNSEL   = 4'h5;
	localparam logic [3:0] PBQ_OFS_ALLOCR  = 4'h6;
	localparam logic [3:0] PBQ_OFS_FLAGS   = 4'h7;
	localparam logic [3:0] PBQ_OFS_MASK    = 4'h8;
	localparam logic [3:0] PBQ_OFS_DONEQ   = 4'h9;
	localparam logic [3:0] PBQ_OFS_RXQ     = 4'hA;
	// control bits
	localparam int PBQ_CTRL_TXEN  = 0;
	localparam int PBQ_CTRL_AUTO  = 1;
	// flag bits
	localparam int PBQ_FLG_RX     = 0;
	localparam int PBQ_FLG_TXDONE = 1;
	localparam int PBQ_FLG_TXEMP  = 2;
	localparam int PBQ_FLG_ALLOC  = 3;
	// host commands, code in bits 3:0, page count in 15:8
	localparam logic [3:0] PBQ_CMD_ALLOC   = 4'h1;
	localparam logic [3:0] PBQ_CMD_RELEASE = 4'h2;
	localparam logic [3:0] PBQ_CMD_ENQUEUE = 4'h3;
	localparam logic [3:0] PBQ_CMD_POP_RX  = 4'h4;
	localparam logic [3:0] PBQ_CMD_POP_TX  = 4'h5;
	localparam logic [15:0] PBQ_CTRL_RST    = 16'h0000;
	localparam logic [15:0] PBQ_RESERVE_RST = 16'h0000;
	localparam logic [3:0]  PBQ_MASK_RST    = 4'h0;
	localparam logic [15:0] PBQ_ALLOC_FAIL  = 16'h8000;
endpackage

// >>> hdl/pbq_top.sv
/*
 packet buffer queue manager: page allocation with transmit reserve,
 packet number issue, tx/rx/done queues and queue-driven flags.
 assumes a host register port and a network engine port on one clock.
*/
// Implementation choices: the plain strobed port and the register addresses.
//Function
//- writer side requests buffers, host or engine
//- receive allocation fails below transmit reserve
//- receive allocation resumes once free exceeds reserve
//- zero reserve: first come first served
//- reserve writable anytime, effective immediately
//- raised reserve lets ongoing receptions finish
//- free and total size readable only
//- outcome words kept with packet, no wait
//- receive flag while rx queue non-empty
//- done flag while completion queue non-empty
//- empty flag while tx queue empty
//- auto-free releases good packets silently
//- auto-free still reports fatal errors
//- otherwise completions queued in finish order
//- allocation flag clears on request
//- numbers unique until space released
//- overrun drops packet, frees its pages
//- tx failure sets done, clears enable
`timescale 1ns/100ps
module pbq_top
	import pbq_pkg::*;
#(
	parameter int PAGES = PBQ_PAGES
)(
	input  wire logic                  clk,
	input  wire logic                  rst_b,
	input  wire logic [PBQ_ADDR_W-1:0] reg_addr,
	input  wire logic [PBQ_DATA_W-1:0] reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [PBQ_DATA_W-1:0] reg_rdata,
	input  wire logic                  rx_start,
	input  wire logic [7:0]            rx_pages,
	output logic                       rx_grant,
	output logic                       rx_refused,
	output logic      [PBQ_PNUM_W-1:0] rx_pnum,
	input  wire logic                  rx_overrun,
	input  wire logic                  rx_good,
	input  wire logic                  rx_bad,
	input  wire logic [PBQ_STAT_W-1:0] rx_status,
	output logic                       tx_req,
	output logic      [PBQ_PNUM_W-1:0] tx_pnum,
	input  wire logic                  tx_done,
	input  wire logic                  tx_ok,
	input  wire logic [PBQ_STAT_W-1:0] tx_status,
	output logic                       irq
);
	localparam int QW = PBQ_PNUM_W + PBQ_STAT_W;
	localparam int NP = 1 << PBQ_PNUM_W;

	logic [15:0]         ctrl_reg, ctrl_next;
	logic [15:0]         reserve_reg, reserve_next;
	logic [7:0]          free_reg, free_next;
	logic [PBQ_PNUM_W-1:0] pnsel_reg, pnsel_next;
	logic [15:0]         allocr_reg, allocr_next;
	logic                alloc_done_reg, alloc_done_next;
	logic [3:0]          mask_reg, mask_next;
	logic [NP-1:0]       used_reg, used_next;
	logic [7:0]          size_reg [NP];
	logic [7:0]          size_next [NP];
	logic [PBQ_STAT_W-1:0] stat_reg [NP];
	logic [PBQ_STAT_W-1:0] stat_next [NP];
	logic                rx_act_reg, rx_act_next;
	logic [PBQ_PNUM_W-1:0] rx_pn_reg, rx_pn_next;
	logic                tx_busy_reg, tx_busy_next;
	logic [PBQ_DATA_W-1:0] rdata_reg, rdata_next;
	logic [3:0]          flags;

	pbq_fifo_if #(.W(QW)) txq ();
	pbq_fifo_if #(.W(QW)) rxq ();
	pbq_fifo_if #(.W(QW)) dnq ();

	pbq_fifo #(.W(QW), .DEPTH(NP)) u_txq (.clk(clk), .rst_b(rst_b),
		.q(txq));
	pbq_fifo #(.W(QW), .DEPTH(NP)) u_rxq (.clk(clk), .rst_b(rst_b),
		.q(rxq));
	pbq_fifo #(.W(QW), .DEPTH(NP)) u_dnq (.clk(clk), .rst_b(rst_b),
		.q(dnq));

	// lowest unused packet number, or NP when none left
	function automatic logic [PBQ_PNUM_W:0] pick_free(
		input logic [NP-1:0] used);
		logic [PBQ_PNUM_W:0] r;
		r = (PBQ_PNUM_W + 1)'(NP);
		for (int i = NP - 1; i >= 0; i--)
			if (!used[i])
				r = (PBQ_PNUM_W + 1)'(i);
		return r;
	endfunction

	logic                host_cmd;
	logic [3:0]          cmd_code;
	logic [7:0]          cmd_pages;
	logic [PBQ_PNUM_W:0] pick;
	logic                host_alloc_ok;
	logic                rx_alloc_ok;

	always_comb
	begin
		host_cmd  = reg_wr && (reg_addr == PBQ_OFS_CMD);
		cmd_code  = reg_wdata[3:0];
		cmd_pages = reg_wdata[15:8];
		pick      = pick_free(used_reg);
		// host request arbitrated first in the cycle, engine refused when host allocates
		host_alloc_ok = host_cmd && (cmd_code == PBQ_CMD_ALLOC)
			&& !pick[PBQ_PNUM_W] && (cmd_pages <= free_reg)
			&& (cmd_pages != 8'h00);
		rx_alloc_ok = rx_start && !host_alloc_ok && !pick[PBQ_PNUM_W]
			&& (rx_pages != 8'h00) && (rx_pages <= free_reg)
			&& ({8'h00, free_reg} > reserve_reg);
	end

	always_comb
	begin
		ctrl_next       = ctrl_reg;
		reserve_next    = reserve_reg;
		free_next       = free_reg;
		pnsel_next      = pnsel_reg;
		allocr_next     = allocr_reg;
		alloc_done_next = alloc_done_reg;
		mask_next       = mask_reg;
		used_next       = used_reg;
		size_next       = size_reg;
		stat_next       = stat_reg;
		rx_act_next     = rx_act_reg;
		rx_pn_next      = rx_pn_reg;
		tx_busy_next    = tx_busy_reg;
		rx_grant        = 1'b0;
		rx_refused      = 1'b0;
		txq.push = 1'b0;
		txq.push_data = '0;
		txq.pop = 1'b0;
		rxq.push = 1'b0;
		rxq.push_data = '0;
		rxq.pop = 1'b0;
		dnq.push = 1'b0;
		dnq.push_data = '0;
		dnq.pop = 1'b0;
		if (reg_wr)
		begin
			case (reg_addr)
			PBQ_OFS_CTRL:    ctrl_next = reg_wdata;
			PBQ_OFS_RESERVE: reserve_next = reg_wdata;
			PBQ_OFS_PNSEL:   pnsel_next = reg_wdata[PBQ_PNUM_W-1:0];
			PBQ_OFS_MASK:    mask_next = reg_wdata[3:0];
			default: ;
			endcase
		end
		// page release: host command, drop or auto-free; host release checks the used bit, auto-free has no guard against a second release
		if (host_cmd)
		begin
			case (cmd_code)
			PBQ_CMD_ALLOC:
			begin
				alloc_done_next = 1'b0;
				allocr_next = PBQ_ALLOC_FAIL;
				if (host_alloc_ok)
				begin
					used_next[pick[PBQ_PNUM_W-1:0]] = 1'b1;
					size_next[pick[PBQ_PNUM_W-1:0]] = cmd_pages;
					free_next = free_next - cmd_pages;
					allocr_next = {11'h000, pick[PBQ_PNUM_W-1:0]};
					alloc_done_next = 1'b1;
				end
			end
			PBQ_CMD_RELEASE:
				if (used_reg[pnsel_reg])
				begin
					used_next[pnsel_reg] = 1'b0;
					free_next = free_next + size_reg[pnsel_reg];
				end
			PBQ_CMD_ENQUEUE:
			begin
				txq.push = 1'b1;
				txq.push_data = {pnsel_reg, stat_reg[pnsel_reg]};
			end
			PBQ_CMD_POP_RX:  rxq.pop = 1'b1;
			PBQ_CMD_POP_TX:  dnq.pop = 1'b1;
			default: ;
			endcase
		end
		if (rx_start && !rx_act_reg)
		begin
			if (rx_alloc_ok)
			begin
				rx_grant = 1'b1;
				rx_act_next = 1'b1;
				rx_pn_next = pick[PBQ_PNUM_W-1:0];
				used_next[pick[PBQ_PNUM_W-1:0]] = 1'b1;
				size_next[pick[PBQ_PNUM_W-1:0]] = rx_pages;
				free_next = free_next - rx_pages;
			end
			else
				rx_refused = 1'b1;
		end
		if (rx_act_reg)
		begin
			if (rx_overrun || rx_bad)
			begin
				rx_act_next = 1'b0;
				used_next[rx_pn_reg] = 1'b0;
				free_next = free_next + size_reg[rx_pn_reg];
			end
			else if (rx_good)
			begin
				rx_act_next = 1'b0;
				stat_next[rx_pn_reg] = rx_status;
				rxq.push = 1'b1;
				rxq.push_data = {rx_pn_reg, rx_status};
			end
		end
		if (ctrl_reg[PBQ_CTRL_TXEN] && txq.not_empty && !tx_busy_reg)
		begin
			tx_busy_next = 1'b1;
		end
		if (tx_busy_reg && tx_done)
		begin
			tx_busy_next = 1'b0;
			txq.pop = 1'b1;
			stat_next[tx_pnum] = tx_status;
			if (tx_ok && ctrl_reg[PBQ_CTRL_AUTO])
			begin
				used_next[tx_pnum] = 1'b0;
				free_next = free_next + size_reg[tx_pnum];
			end
			else
			begin
				dnq.push = 1'b1;
				dnq.push_data = {tx_pnum, tx_status};
			end
			if (!tx_ok)
				ctrl_next[PBQ_CTRL_TXEN] = 1'b0;
		end
	end

	always_comb
	begin
		flags[PBQ_FLG_RX]     = rxq.not_empty;
		flags[PBQ_FLG_TXDONE] = dnq.not_empty;
		flags[PBQ_FLG_TXEMP]  = !txq.not_empty;
		flags[PBQ_FLG_ALLOC]  = alloc_done_reg;
		rdata_next = '0;
		if (reg_rd)
		begin
			case (reg_addr)
			PBQ_OFS_CTRL:    rdata_next = ctrl_reg;
			PBQ_OFS_RESERVE: rdata_next = reserve_reg;
			PBQ_OFS_FREE:    rdata_next = {8'h00, free_reg};
			PBQ_OFS_SIZE:    rdata_next = 16'(PAGES);
			PBQ_OFS_PNSEL:   rdata_next = {11'h000, pnsel_reg};
			PBQ_OFS_ALLOCR:  rdata_next = allocr_reg;
			PBQ_OFS_FLAGS:   rdata_next = {12'h000, flags};
			PBQ_OFS_MASK:    rdata_next = {12'h000, mask_reg};
			PBQ_OFS_DONEQ:   rdata_next = {dnq.not_empty, 10'h000,
				dnq.head[QW-1:PBQ_STAT_W]};
			PBQ_OFS_RXQ:     rdata_next = {rxq.not_empty, 10'h000,
				rxq.head[QW-1:PBQ_STAT_W]};
			default:         rdata_next = '0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ctrl_reg       <= PBQ_CTRL_RST;
			reserve_reg    <= PBQ_RESERVE_RST;
			free_reg       <= 8'(PAGES);
			pnsel_reg      <= '0;
			allocr_reg     <= PBQ_ALLOC_FAIL;
			alloc_done_reg <= 1'b0;
			mask_reg       <= PBQ_MASK_RST;
			used_reg       <= '0;
			rx_act_reg     <= 1'b0;
			rx_pn_reg      <= '0;
			tx_busy_reg    <= 1'b0;
			rdata_reg      <= '0;
			irq            <= 1'b0;
			for (int i = 0; i < NP; i++)
			begin
				size_reg[i] <= '0;
				stat_reg[i] <= '0;
			end
		end
		else
		begin
			ctrl_reg       <= ctrl_next;
			reserve_reg    <= reserve_next;
			free_reg       <= free_next;
			pnsel_reg      <= pnsel_next;
			allocr_reg     <= allocr_next;
			alloc_done_reg <= alloc_done_next;
			mask_reg       <= mask_next;
			used_reg       <= used_next;
			rx_act_reg     <= rx_act_next;
			rx_pn_reg      <= rx_pn_next;
			tx_busy_reg    <= tx_busy_next;
			rdata_reg      <= rdata_next;
			irq            <= |(flags & mask_reg);
			size_reg       <= size_next;
			stat_reg       <= stat_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign tx_req    = tx_busy_reg;
	assign tx_pnum   = txq.head[QW-1:PBQ_STAT_W];
	assign rx_pnum   = rx_pn_reg;
endmodule

// >>> sim/pbq_chk.sv
/* port checker for pbq_top.
 assumes a bind into pbq_top and one clock domain. */
`timescale 1ns/100ps
module pbq_chk
	import pbq_pkg::*;
#(
	parameter int PAGES = PBQ_PAGES
)(
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic [3:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic        rx_start,
	input wire logic [7:0]  rx_pages,
	input wire logic        rx_grant,
	input wire logic        rx_refused,
	input wire logic        tx_req,
	input wire logic        tx_done,
	input wire logic        tx_ok,
	input wire logic        irq
);
	logic [3:0]  mask_reg;
	logic [3:0]  mask_next;
	logic [15:0] rsv_reg;
	logic [15:0] rsv_next;
	always_comb
	begin
		mask_next = mask_reg;
		rsv_next = rsv_reg;
		if (reg_wr && reg_addr == PBQ_OFS_MASK)
			mask_next = reg_wdata[3:0];
		if (reg_wr && reg_addr == PBQ_OFS_RESERVE)
			rsv_next = reg_wdata;
	end
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
		begin
			mask_reg <= PBQ_MASK_RST;
			rsv_reg <= PBQ_RESERVE_RST;
		end
		else
		begin
			mask_reg <= mask_next;
			rsv_reg <= rsv_next;
		end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_size_rd;
		reg_rd && reg_addr == PBQ_OFS_SIZE;
	endsequence
	sequence s_tx_fail;
		tx_req && tx_done && !tx_ok;
	endsequence
	a_rx_answer_excl: assert property (!(rx_grant && rx_refused))
		else $error("grant and refusal together");
	a_size_read: assert property (s_size_rd |=> reg_rdata == PAGES)
		else $error("size read wrong");
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data outside read slot");
	a_tx_req_drop: assert property (tx_req && tx_done |=> !tx_req)
		else $error("tx request held after done");
	a_tx_fail_stop: assert property (s_tx_fail |=> !tx_req [*2])
		else $error("tx continued after failure");
	a_rx_too_big: assert property (rx_start && rx_pages > PAGES |-> !rx_grant)
		else $error("oversized receive granted");
	a_rx_reserve: assert property (rx_start && rsv_reg >= PAGES |-> !rx_grant)
		else $error("receive granted under reserve");
	a_irq_masked: assert property ((mask_reg == 4'h0) [*2] |-> !irq)
		else $error("interrupt with all enables off");
endmodule

// >>> sim/pbq_eng_model.sv
/* network engine model: receive page requests and tx completions.
 assumes tasks called from the bench on clk. */
`timescale 1ns/100ps
module pbq_eng_model (
	input  wire logic        clk,
	input  wire logic        rx_grant,
	input  wire logic        rx_refused,
	input  wire logic        tx_req,
	output logic             rx_start,
	output logic      [7:0]  rx_pages,
	output logic             rx_overrun,
	output logic             rx_good,
	output logic             rx_bad,
	output logic      [15:0] rx_status,
	output logic             tx_done,
	output logic             tx_ok,
	output logic      [15:0] tx_status
);
	initial
	begin
		{rx_start, rx_overrun, rx_good, rx_bad, tx_done} = 5'h00;
		{rx_pages, rx_status, tx_ok, tx_status} = 41'h0;
	end
	// engine asks for pages of its own packet
	task rx_begin(input logic [7:0] p, output logic g);
		@(posedge clk);
		rx_start <= 1'b1;
		rx_pages <= p;
		// x unless exactly one of grant and refusal answers
		#1 g = (rx_grant != rx_refused) ? rx_grant : 1'bx;
		@(posedge clk);
		rx_start <= 1'b0;
		rx_pages <= ~p;
	endtask
	// kind 0 good, 1 bad, 2 overrun
	task rx_end(input int k);
		repeat (2) @(posedge clk);
		rx_good <= (k == 0);
		rx_bad <= (k == 1);
		rx_overrun <= (k == 2);
		rx_status <= 16'h00A5;
		@(posedge clk);
		{rx_good, rx_bad, rx_overrun} <= 3'h0;
		rx_status <= 16'hFF5A;
	endtask
	task tx_finish(input logic ok, input logic [15:0] st, output logic s);
		s = 1'b0;
		repeat (20)
		begin
			@(posedge clk);
			#1 s = tx_req;
			if (s)
				break;
		end
		@(posedge clk);
		tx_done <= 1'b1;
		tx_ok <= ok;
		tx_status <= st;
		@(posedge clk);
		tx_done <= 1'b0;
		tx_ok <= ~ok;
		tx_status <= ~st;
	endtask
endmodule

// >>> sim/test_pbq_top.sv
/* self-checking bench for pbq_top.
 assumes pbq_pkg, design, engine model and checker compiled first. */
`timescale 1ns/100ps
module test_pbq_top
	import pbq_pkg::*;
;
	logic clk, rst_b, reg_wr, reg_rd, irq, g, s;
	logic [3:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, rx_status, tx_status, d, f;
	logic rx_start, rx_grant, rx_refused, rx_overrun, rx_good, rx_bad;
	logic tx_req, tx_done, tx_ok;
	logic [7:0] rx_pages;
	logic [4:0] rx_pnum, tx_pnum, pa, pb;
	int mismatches, tests_run;
	pbq_top u_pbq_top (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .rx_start(rx_start), .rx_pages(rx_pages),
		.rx_grant(rx_grant), .rx_refused(rx_refused), .rx_pnum(rx_pnum),
		.rx_overrun(rx_overrun), .rx_good(rx_good), .rx_bad(rx_bad),
		.rx_status(rx_status), .tx_req(tx_req), .tx_pnum(tx_pnum),
		.tx_done(tx_done), .tx_ok(tx_ok), .tx_status(tx_status), .irq(irq));
	pbq_eng_model u_eng (.clk(clk), .rx_grant(rx_grant), .tx_req(tx_req),
		.rx_refused(rx_refused),
		.rx_start(rx_start), .rx_pages(rx_pages), .rx_overrun(rx_overrun),
		.rx_good(rx_good), .rx_bad(rx_bad), .rx_status(rx_status),
		.tx_done(tx_done), .tx_ok(tx_ok), .tx_status(tx_status));
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task print_verdict;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [15:0] gv, input logic [15:0] e);
		tests_run++;
		if (gv !== e)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, gv, e);
		end
	endtask
	task wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [3:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task rdc(input logic [3:0] a, input logic [15:0] e);
		rd(a);
		chk(d, e);
	endtask
	task chkf(input int b, input logic e);
		rd(PBQ_OFS_FLAGS);
		chk(16'(d[b]), 16'(e));
	endtask
	task cmd(input logic [3:0] c, input logic [7:0] n);
		wr(PBQ_OFS_CMD, {n, 4'h0, c});
	endtask
	task t_regs;
		rdc(PBQ_OFS_SIZE, 16'(PBQ_PAGES));
		wr(PBQ_OFS_FREE, 16'h0000);
		rdc(PBQ_OFS_FREE, 16'(PBQ_PAGES));
		rdc(4'hF, 16'h0000);
		$display("regs done");
	endtask
	task t_alloc;
		cmd(PBQ_CMD_ALLOC, 8'h04);
		chkf(PBQ_FLG_ALLOC, 1'b1);
		rd(PBQ_OFS_ALLOCR);
		pa = d[4:0];
		chk(d & PBQ_ALLOC_FAIL, 16'h0000);
		cmd(PBQ_CMD_ALLOC, 8'h00);
		chkf(PBQ_FLG_ALLOC, 1'b0);
		cmd(PBQ_CMD_ALLOC, 8'h02);
		rd(PBQ_OFS_ALLOCR);
		pb = d[4:0];
		chk(16'(pb != pa), 16'h0001);
		rdc(PBQ_OFS_FREE, 16'h0012);
		$display("alloc done");
	endtask
	task t_rx;
		wr(PBQ_OFS_RESERVE, 16'h0018);
		u_eng.rx_begin(8'h01, g);
		chk(16'(g), 16'h0000);
		wr(PBQ_OFS_RESERVE, 16'h0000);
		u_eng.rx_begin(8'h20, g);
		chk(16'(g), 16'h0000);
		u_eng.rx_begin(8'h03, g);
		chk(16'(g), 16'h0001);
		#1 chk(16'(rx_pnum != pa && rx_pnum != pb), 16'h0001);
		u_eng.rx_end(2);
		rdc(PBQ_OFS_FREE, 16'h0012);
		u_eng.rx_begin(8'h02, g);
		wr(PBQ_OFS_RESERVE, 16'h0014);
		u_eng.rx_end(0);
		chkf(PBQ_FLG_RX, 1'b1);
		wr(PBQ_OFS_MASK, 16'h0001);
		repeat (2) @(posedge clk);
		#1 chk(16'(irq), 16'h0001);
		u_eng.rx_begin(8'h01, g);
		chk(16'(g), 16'h0000);
		cmd(PBQ_CMD_POP_RX, 8'h00);
		chkf(PBQ_FLG_RX, 1'b0);
		wr(PBQ_OFS_MASK, 16'h0000);
		wr(PBQ_OFS_RESERVE, 16'h0000);
		$display("rx done");
	endtask
	task t_tx;
		wr(PBQ_OFS_PNSEL, 16'(pa));
		cmd(PBQ_CMD_ENQUEUE, 8'h00);
		chkf(PBQ_FLG_TXEMP, 1'b0);
		wr(PBQ_OFS_MASK, 16'h0002);
		wr(PBQ_OFS_CTRL, 16'h0001);
		u_eng.tx_finish(1'b1, 16'h1234, s);
		chk(16'(s), 16'h0001);
		repeat (2) @(posedge clk);
		#1 chk(16'(irq), 16'h0001);
		chkf(PBQ_FLG_TXDONE, 1'b1);
		chkf(PBQ_FLG_TXEMP, 1'b1);
		rd(PBQ_OFS_DONEQ);
		chk({d[15], 10'h0, d[4:0]}, {1'b1, 10'h0, pa});
		cmd(PBQ_CMD_POP_TX, 8'h00);
		chkf(PBQ_FLG_TXDONE, 1'b0);
		chk(16'(irq), 16'h0000);
		rd(PBQ_OFS_FREE);
		f = d;
		wr(PBQ_OFS_CTRL, 16'h0003);
		wr(PBQ_OFS_MASK, 16'h0006);
		wr(PBQ_OFS_PNSEL, 16'(pb));
		cmd(PBQ_CMD_ENQUEUE, 8'h00);
		#1 chk(16'(tx_pnum), 16'(pb));
		u_eng.tx_finish(1'b1, 16'h1234, s);
		chk(16'(s), 16'h0001);
		repeat (2) @(posedge clk);
		#1 chk(16'(irq), 16'h0001);
		chkf(PBQ_FLG_TXDONE, 1'b0);
		rdc(PBQ_OFS_FREE, f + 16'h0002);
		rd(PBQ_OFS_PNSEL);
		f = d;
		wr(PBQ_OFS_PNSEL, 16'(pa));
		cmd(PBQ_CMD_ENQUEUE, 8'h00);
		wr(PBQ_OFS_PNSEL, f);
		rdc(PBQ_OFS_PNSEL, 16'(pb));
		u_eng.tx_finish(1'b0, 16'h0040, s);
		chk(16'(s), 16'h0001);
		repeat (2) @(posedge clk);
		chkf(PBQ_FLG_TXDONE, 1'b1);
		rdc(PBQ_OFS_CTRL, 16'h0002);
		$display("tx done");
	endtask
	initial
	begin
		{rst_b, reg_wr, reg_rd, reg_addr, reg_wdata} = 23'h0;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		t_regs;
		t_alloc;
		t_rx;
		t_tx;
		print_verdict;
	end
	initial
	begin
		repeat (3000) @(posedge clk);
		mismatches++;
		print_verdict;
	end
endmodule
bind pbq_top pbq_chk #(.PAGES(PAGES)) u_chk (.clk(clk), .rst_b(rst_b),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_start(rx_start),
	.rx_pages(rx_pages), .rx_grant(rx_grant), .rx_refused(rx_refused),
	.tx_req(tx_req), .tx_done(tx_done), .tx_ok(tx_ok), .irq(irq));
